// ---- act_timer_regs.svh ----
/*
  register offsets, reset values, field positions and timing counts of the
  cascadable auxiliary timer block.
  assumes: included by bare name into the design files; the package does not include it.
*/
`ifndef ACT_TIMER_REGS_SVH
`define ACT_TIMER_REGS_SVH

// =====================================================================
// register offsets (byte addresses)
`define ACT_PER1_OFF   8'h00
`define ACT_CMP1_OFF   8'h04
`define ACT_PER2_OFF   8'h08
`define ACT_CMP2_OFF   8'h0c
`define ACT_PER3_OFF   8'h10
`define ACT_CMP3_OFF   8'h14
`define ACT_GATE_OFF   8'h18
`define ACT_OSEL1_OFF  8'h1c
`define ACT_OSEL2_OFF  8'h20
`define ACT_OSEL3_OFF  8'h24
`define ACT_DISP_OFF   8'h28
`define ACT_MODE1_OFF  8'h2c
`define ACT_MODE2_OFF  8'h30
`define ACT_MODE3_OFF  8'h34
`define ACT_STAT_OFF   8'h38
`define ACT_MASK_OFF   8'h3c
`define ACT_VAL1_OFF   8'h40
`define ACT_VAL2_OFF   8'h44
`define ACT_VAL3_OFF   8'h48

// =====================================================================
// reset values
`define ACT_PER_RST    16'h7530
`define ACT_CMP_RST    16'h2710
`define ACT_GATE_RST   16'h0000
`define ACT_OSEL_RST   16'h0041
`define ACT_DISP_RST   16'h0000
`define ACT_MODE_RST   16'h0000

// =====================================================================
// mode word digit positions
`define ACT_MODE_CLK   3:0
`define ACT_MODE_START 7:4
`define ACT_MODE_RSRC  11:8
`define ACT_MODE_CYC   12

// =====================================================================
// timing
`define ACT_CLK_PERIOD_NS 25
`define ACT_MS_NS      1000000
`define ACT_PULSE_MS   500
`define ACT_SEC_MS     1000
`define ACT_MIN_SEC    60
`define ACT_UNIT_S_MS  22'h0003e8
`define ACT_UNIT_M_MS  22'h00ea60
`define ACT_UNIT_H_MS  22'h36ee80

`endif

// ---- act_timer_pkg.sv ----
/*
  types shared by the auxiliary timer design files.
  assumes: nothing beyond the register header.
*/
package act_timer_pkg;
  // gray along idle -> run -> done
  typedef enum logic [1:0] {
    ACT_IDLE = 2'b00,
    ACT_RUN  = 2'b01,
    ACT_DONE = 2'b11
  } act_state_t;

  typedef struct packed {
    logic [15:0] per;
    logic [15:0] cmp;
    logic        multi;
    logic [3:0]  rsrc;
    logic [3:0]  unit;
  } act_tmr_cfg_t;

  typedef struct packed {
    logic started;
    logic cmpEv;
    logic cycEv;
    logic cmpLvl;
    logic cycLvl;
  } act_tmr_evt_t;
endpackage

// ---- act_timer_out.sv ----
/*
  one selectable timer output: pulse, level or toggle.
  assumes: events are one-cycle pulses; msTick is the free millisecond enable.
*/
`timescale 1ns/1ps
`include "act_timer_regs.svh"
module act_timer_out import act_timer_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         msTick,
  input  wire logic         clr,
  input  wire logic [3:0]   code,
  input  wire act_tmr_evt_t evt,
  output logic              sigOut
);
  localparam logic [9:0] PULSE_MS = 10'(`ACT_PULSE_MS);

  logic [9:0] pulse_r;
  logic       tog_r;
  logic       sigOut_r;

  wire pulseEv = (code == 4'h0 && evt.cmpEv) || (code == 4'h3 && evt.cycEv);
  wire togEv   = (code == 4'h2 && evt.cmpEv) || (code == 4'h5 && evt.cycEv) ||
                 (code == 4'h6 && (evt.cmpEv || evt.cycEv));
  wire sigNxt  = (code == 4'h0 || code == 4'h3) ? (pulse_r != 10'h000) :
                 (code == 4'h1) ? evt.cmpLvl :
                 (code == 4'h4) ? evt.cycLvl :
                 (code == 4'h2 || code == 4'h5 || code == 4'h6) ? tog_r : 1'b0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_r  <= 10'h000;
      tog_r    <= 1'b0;
      sigOut_r <= 1'b0;
    end else begin
      // pulse length counts the free ms reference, not the timer tick
      // a clear drops a running pulse as well, so no stale status survives it
      if (clr) begin
        pulse_r <= 10'h000;
      end else if (pulseEv) begin
        pulse_r <= PULSE_MS;
      end else if (msTick && pulse_r != 10'h000) begin
        pulse_r <= pulse_r - 10'h001;
      end
      if (clr) begin
        tog_r <= 1'b0;
      end else if (togEv) begin
        tog_r <= ~tog_r;
      end
      sigOut_r <= sigNxt;
    end
  end

  assign sigOut = sigOut_r;
endmodule

// ---- act_timer_core.sv ----
/*
  one auxiliary timer: count, compare, cycle, single or multi cycle and
  scaled display value.
  assumes: tick and startEv are one-cycle enables and clrReq is a level, all already selected.
*/
`timescale 1ns/1ps
`include "act_timer_regs.svh"
module act_timer_core import act_timer_pkg::*; (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         tick,
  input  wire logic         msTick,
  input  wire logic         gateOk,
  input  wire logic         startEv,
  input  wire logic         clrReq,
  input  wire act_tmr_cfg_t cfg,
  output act_tmr_evt_t      evt,
  output logic [15:0]       value
);
  act_state_t  state_r;
  logic [15:0] cnt_r;
  logic        cycLvl_r;
  logic [21:0] msAcc_r;
  logic [15:0] disp_r;

  wire        running = state_r == ACT_RUN;
  wire        adv     = running && tick && gateOk;
  wire [15:0] cntInc  = cnt_r + 16'h0001;
  wire        hitCmp  = adv && cntInc == cfg.cmp;
  wire        hitCyc  = adv && (cntInc == cfg.per || cnt_r >= cfg.per);
  wire        started = state_r == ACT_IDLE && startEv;
  wire [21:0] unitMs  = (cfg.unit == 4'h1) ? `ACT_UNIT_S_MS :
                        (cfg.unit == 4'h2) ? `ACT_UNIT_M_MS : `ACT_UNIT_H_MS;
  wire        clrDisp = clrReq || started || (hitCyc && (cfg.multi || cfg.rsrc != 4'h0));
  wire        unitEnd = msAcc_r + 22'h000001 >= unitMs;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r  <= ACT_IDLE;
      cnt_r    <= 16'h0000;
      cycLvl_r <= 1'b0;
    end else if (clrReq) begin
      state_r  <= ACT_IDLE;
      cnt_r    <= 16'h0000;
      cycLvl_r <= 1'b0;
    end else begin
      case (state_r)
        ACT_IDLE: begin
          if (startEv) begin
            state_r  <= ACT_RUN;
            cnt_r    <= 16'h0000;
            cycLvl_r <= 1'b0;
          end
        end
        ACT_RUN: begin
          if (hitCyc) begin
            cycLvl_r <= 1'b1;
            if (cfg.multi) begin
              cnt_r <= 16'h0000;
            end else if (cfg.rsrc == 4'h2) begin
              state_r  <= ACT_IDLE;
              cnt_r    <= 16'h0000;
              cycLvl_r <= 1'b0;
            end else begin
              state_r <= ACT_DONE;
              cnt_r   <= (cfg.rsrc == 4'h1) ? 16'h0000 : cntInc;
            end
          end else if (adv) begin
            cnt_r <= cntInc;
          end
        end
        ACT_DONE: begin
          // waits for a clear, then a fresh start from idle
          state_r <= ACT_DONE;
        end
        default: begin
          state_r <= ACT_IDLE;
        end
      endcase
    end
  end

  // elapsed time in the display unit, kept beside the raw count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msAcc_r <= 22'h000000;
      disp_r  <= 16'h0000;
    end else if (clrDisp) begin
      msAcc_r <= 22'h000000;
      disp_r  <= 16'h0000;
    end else if (running && gateOk && msTick) begin
      msAcc_r <= unitEnd ? 22'h000000 : msAcc_r + 22'h000001;
      disp_r  <= unitEnd ? disp_r + 16'h0001 : disp_r;
    end
  end

  assign evt.started = started;
  assign evt.cmpEv   = hitCmp;
  assign evt.cycEv   = hitCyc;
  assign evt.cmpLvl  = state_r != ACT_IDLE && (cnt_r >= cfg.cmp || cycLvl_r);
  assign evt.cycLvl  = cycLvl_r;
  assign value       = (cfg.unit == 4'h0) ? cnt_r : disp_r;
endmodule

// ---- act_timer_top.sv ----
/*
  three cascadable auxiliary timers with an APB register file, six selectable
  outputs and one level interrupt.
  assumes: all inputs synchronous to clk; APB master per the AMBA 3 protocol.
*/
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "act_timer_regs.svh"
module act_timer_top import act_timer_pkg::*; #(
  parameter int MS_CYCLES = `ACT_MS_NS / `ACT_CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [2:0]  mfiGate,
  input  wire logic [2:0]  mfiStart,
  input  wire logic [2:0]  mfiReset,
  input  wire logic        driveRun,
  output logic [5:0]       timerOut,
  output logic             irq
);
  localparam logic [2:0][7:0] PER_OFF  = {`ACT_PER3_OFF, `ACT_PER2_OFF, `ACT_PER1_OFF};
  localparam logic [2:0][7:0] CMP_OFF  = {`ACT_CMP3_OFF, `ACT_CMP2_OFF, `ACT_CMP1_OFF};
  localparam logic [2:0][7:0] OSEL_OFF = {`ACT_OSEL3_OFF, `ACT_OSEL2_OFF, `ACT_OSEL1_OFF};
  localparam logic [2:0][7:0] MODE_OFF = {`ACT_MODE3_OFF, `ACT_MODE2_OFF, `ACT_MODE1_OFF};
  localparam logic [15:0] MS_LAST  = 16'(MS_CYCLES - 1);
  localparam logic [9:0]  SEC_LAST = 10'(`ACT_SEC_MS - 1);
  localparam logic [5:0]  MIN_LAST = 6'(`ACT_MIN_SEC - 1);

  // =====================================================================
  // apb slave
  logic [2:0][15:0] per_r;
  logic [2:0][15:0] cmp_r;
  logic [2:0][15:0] osel_r;
  logic [2:0][15:0] mode_r;
  logic [15:0]      gate_r;
  logic [15:0]      disp_r;
  logic [5:0]       status_r;
  logic [5:0]       mask_r;
  logic [31:0]      prdata_r;
  logic [31:0]      rdMux;
  logic             hit;
  logic [2:0][15:0] value;
  act_tmr_evt_t     evt [3];

  wire wrEn    = psel && penable && pwrite;
  wire setupRd = psel && !penable;
  wire wrStat  = wrEn && paddr == `ACT_STAT_OFF;

  // zero wait states: read data is captured in the setup cycle
  always_comb begin
    hit   = 1'b1;
    rdMux = 32'h00000000;
    case (paddr)
      `ACT_PER1_OFF:  rdMux = {16'h0000, per_r[0]};
      `ACT_CMP1_OFF:  rdMux = {16'h0000, cmp_r[0]};
      `ACT_PER2_OFF:  rdMux = {16'h0000, per_r[1]};
      `ACT_CMP2_OFF:  rdMux = {16'h0000, cmp_r[1]};
      `ACT_PER3_OFF:  rdMux = {16'h0000, per_r[2]};
      `ACT_CMP3_OFF:  rdMux = {16'h0000, cmp_r[2]};
      `ACT_GATE_OFF:  rdMux = {16'h0000, gate_r};
      `ACT_OSEL1_OFF: rdMux = {16'h0000, osel_r[0]};
      `ACT_OSEL2_OFF: rdMux = {16'h0000, osel_r[1]};
      `ACT_OSEL3_OFF: rdMux = {16'h0000, osel_r[2]};
      `ACT_DISP_OFF:  rdMux = {16'h0000, disp_r};
      `ACT_MODE1_OFF: rdMux = {16'h0000, mode_r[0]};
      `ACT_MODE2_OFF: rdMux = {16'h0000, mode_r[1]};
      `ACT_MODE3_OFF: rdMux = {16'h0000, mode_r[2]};
      `ACT_STAT_OFF:  rdMux = {26'h0000000, status_r};
      `ACT_MASK_OFF:  rdMux = {26'h0000000, mask_r};
      `ACT_VAL1_OFF:  rdMux = {16'h0000, value[0]};
      `ACT_VAL2_OFF:  rdMux = {16'h0000, value[1]};
      `ACT_VAL3_OFF:  rdMux = {16'h0000, value[2]};
      default:        hit   = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
    end else if (setupRd) begin
      prdata_r <= rdMux;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // =====================================================================
  // shared registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gate_r <= `ACT_GATE_RST;
      disp_r <= `ACT_DISP_RST;
      mask_r <= 6'h00;
    end else if (wrEn) begin
      if (paddr == `ACT_GATE_OFF) begin
        gate_r <= pwdata[15:0];
      end
      if (paddr == `ACT_DISP_OFF) begin
        disp_r <= pwdata[15:0];
      end
      if (paddr == `ACT_MASK_OFF) begin
        mask_r <= pwdata[5:0];
      end
    end
  end

  // =====================================================================
  // timebase: ms, s and min enables from one free divider
  logic [15:0] msCnt_r;
  logic [9:0]  secCnt_r;
  logic [5:0]  minCnt_r;
  wire msTick  = msCnt_r == MS_LAST;
  wire secTick = msTick && secCnt_r == SEC_LAST;
  wire minTick = secTick && minCnt_r == MIN_LAST;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msCnt_r  <= 16'h0000;
      secCnt_r <= 10'h000;
      minCnt_r <= 6'h00;
    end else begin
      msCnt_r <= msTick ? 16'h0000 : msCnt_r + 16'h0001;
      if (msTick) begin
        secCnt_r <= (secCnt_r == SEC_LAST) ? 10'h000 : secCnt_r + 10'h001;
      end
      if (secTick) begin
        minCnt_r <= (minCnt_r == MIN_LAST) ? 6'h00 : minCnt_r + 6'h01;
      end
    end
  end

  // =====================================================================
  // edge detection of start and run state inputs
  logic [2:0] mfiStart_r;
  logic       driveRun_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mfiStart_r <= 3'h0;
      driveRun_r <= 1'b0;
    end else begin
      mfiStart_r <= mfiStart;
      driveRun_r <= driveRun;
    end
  end

  wire       runRise   = driveRun && !driveRun_r;
  wire       runFall   = !driveRun && driveRun_r;
  wire [2:0] startEdge = mfiStart & ~mfiStart_r;

  // =====================================================================
  // timers
  logic [5:0] evBits;

  for (genvar i = 0; i < 3; i++) begin : g_tmr
    wire [3:0] clkSel  = mode_r[i][`ACT_MODE_CLK];
    wire [3:0] stSel   = mode_r[i][`ACT_MODE_START];
    wire [3:0] rsrc    = mode_r[i][`ACT_MODE_RSRC];
    wire [3:0] gateSel = gate_r[4*i +: 4];
    // cascade sources only from lower timers, so there is no loop
    wire t1Ok = i >= 1;
    wire t2Ok = i >= 2;
    wire tick = (clkSel == 4'h0) ? msTick :
                (clkSel == 4'h1) ? secTick :
                (clkSel == 4'h2) ? minTick :
                (clkSel == 4'h3 && t1Ok) ? evt[0].cycEv :
                (clkSel == 4'h4 && t2Ok) ? evt[1].cycEv : 1'b0;
    // a gate code not valid for this timer falls back to ungated
    wire gateOk = (gateSel == 4'h1) ? mfiGate[i] :
                  (gateSel == 4'h2 && t1Ok) ? evt[0].cmpLvl :
                  (gateSel == 4'h3 && t1Ok) ? evt[0].cycLvl :
                  (gateSel == 4'h4 && t2Ok) ? evt[1].cmpLvl :
                  (gateSel == 4'h5 && t2Ok) ? evt[1].cycLvl : 1'b1;
    wire startEv = (stSel == 4'h0) ? startEdge[i] :
                   (stSel == 4'h1) ? runRise :
                   (stSel == 4'h2) ? runFall :
                   (stSel == 4'h3 && t1Ok) ? evt[0].started : 1'b0;
    wire clrReq = (rsrc == 4'h0) && mfiReset[i];
    wire cmpClamp = wrEn && paddr == CMP_OFF[i] && pwdata[15:0] > per_r[i];
    wire perClamp = wrEn && paddr == PER_OFF[i] && cmp_r[i] > pwdata[15:0];
    act_tmr_cfg_t cfg;

    assign cfg.per   = per_r[i];
    assign cfg.cmp   = cmp_r[i];
    assign cfg.multi = mode_r[i][`ACT_MODE_CYC];
    assign cfg.rsrc  = rsrc;
    assign cfg.unit  = disp_r[4*i +: 4];

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        per_r[i]  <= `ACT_PER_RST;
        cmp_r[i]  <= `ACT_CMP_RST;
        osel_r[i] <= `ACT_OSEL_RST;
        mode_r[i] <= `ACT_MODE_RST;
      end else if (wrEn) begin
        if (paddr == PER_OFF[i]) begin
          per_r[i] <= pwdata[15:0];
        end
        if (cmpClamp || perClamp) begin
          cmp_r[i] <= cmpClamp ? per_r[i] : pwdata[15:0];
        end else if (paddr == CMP_OFF[i]) begin
          cmp_r[i] <= pwdata[15:0];
        end
        if (paddr == OSEL_OFF[i]) begin
          osel_r[i] <= {8'h00, pwdata[7:0]};
        end
        if (paddr == MODE_OFF[i]) begin
          mode_r[i] <= {3'h0, pwdata[12:0]};
        end
      end
    end

    act_timer_core u_core (
      .clk     (clk),
      .rst_n   (rst_n),
      .tick    (tick),
      .msTick  (msTick),
      .gateOk  (gateOk),
      .startEv (startEv),
      .clrReq  (clrReq),
      .cfg     (cfg),
      .evt     (evt[i]),
      .value   (value[i])
    );

    for (genvar k = 0; k < 2; k++) begin : g_out
      act_timer_out u_out (
        .clk    (clk),
        .rst_n  (rst_n),
        .msTick (msTick),
        .clr    (clrReq),
        .code   (osel_r[i][4*k +: 4]),
        .evt    (evt[i]),
        .sigOut (timerOut[2*i+k])
      );
    end

    assign evBits[2*i]   = evt[i].cmpEv;
    assign evBits[2*i+1] = evt[i].cycEv;
  end

  // =====================================================================
  // interrupt: sticky events, write one to clear, a new event wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_r <= 6'h00;
    end else begin
      status_r <= (status_r & ~(wrStat ? pwdata[5:0] : 6'h00)) | evBits;
    end
  end

  assign irq = |(status_r & mask_r);
endmodule

// ---- act_timer_sva.sv ----
/* port checker of the auxiliary timer block
   assumes: bound to act_timer_top, one clock domain */
`timescale 1ns/1ps
module act_timer_sva (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [2:0]  mfiReset,
  input wire logic [5:0]  timerOut,
  input wire logic        irq
);
  // ==========
  // bus and output relations
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire acc   = psel && penable;
  wire unmap = paddr > 8'h48 || paddr[1:0] != 2'b00;
  property p_ready; pready; endproperty
  a_ready: assert property (p_ready) else $error("pready low");
  property p_errAcc; pslverr |-> acc; endproperty
  a_errAcc: assert property (p_errAcc) else $error("error outside access");
  property p_errMap; acc && unmap |-> pslverr; endproperty
  a_errMap: assert property (p_errMap) else $error("unmapped not refused");
  property p_okMap; acc && !unmap |-> !pslverr; endproperty
  a_okMap: assert property (p_okMap) else $error("mapped refused");
  property p_rdZero; acc && !pwrite && unmap |-> prdata == 32'h0; endproperty
  a_rdZero: assert property (p_rdZero) else $error("unmapped read not zero");
  property p_rdHold; !(psel && !penable) |=> $stable(prdata); endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data moved");
  property p_maskIrq; acc && pwrite && paddr == 8'h3c && pwdata[5:0] == 6'h0 |=> !irq; endproperty
  a_maskIrq: assert property (p_maskIrq) else $error("irq with mask clear");
  // clear is a level: a held clear must win over level outputs
  property p_clrOut; mfiReset[0] [*4] |-> timerOut[1:0] == 2'b00; endproperty
  a_clrOut: assert property (p_clrOut) else $error("output survives clear");
  c_irq: cover property ($rose(irq));
  c_err: cover property (pslverr);
  c_tog: cover property ($fell(timerOut[5]));
endmodule
bind act_timer_top act_timer_sva u_sva (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .mfiReset, .timerOut, .irq);

// ---- act_timer_mfi.sv ----
/* terminal and run-state model in front of the timers
   assumes: commands come from the bench, outputs change after clk */
`timescale 1ns/1ps
module act_timer_mfi (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] gateCmd,
  input  wire logic [2:0] startCmd,
  input  wire logic [2:0] clrCmd,
  input  wire logic       runCmd,
  output logic      [2:0] mfiGate,
  output logic      [2:0] mfiStart,
  output logic      [2:0] mfiReset,
  output logic            driveRun
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mfiGate  <= 3'h0;
      mfiStart <= 3'h0;
      mfiReset <= 3'h0;
      driveRun <= 1'b0;
    end else begin
      mfiGate  <= gateCmd;
      mfiStart <= startCmd;
      mfiReset <= clrCmd;
      driveRun <= runCmd;
    end
  end
endmodule

// ---- aux_cascadable_timer_outputs_tb.sv ----
/* self-checking bench of the auxiliary timer block
   assumes: 4 clocks per ms, apb with no wait states expected */
`timescale 1ns/1ps
module aux_cascadable_timer_outputs_tb;
  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, runCmd, driveRun, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  mfiGate, mfiStart, mfiReset, gateCmd, startCmd, clrCmd;
  logic [5:0]  timerOut;
  int          n_errors, n_compared, cyc, i;
  logic [7:0]  rA [12]   = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h3c};
  logic [15:0] rRst [12] = '{16'h7530, 16'h2710, 16'h7530, 16'h2710, 16'h7530, 16'h2710, 16'h0, 16'h41, 16'h41,
                             16'h41, 16'h0, 16'h0};
  logic [15:0] rExp [12] = '{16'h0100, 16'h0040, 16'hffff, 16'h0080, 16'h0300, 16'h00c0, 16'h0210, 16'h41, 16'h41,
                             16'h52, 16'h0320, 16'h0};
  act_timer_top #(.MS_CYCLES(4)) u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .mfiGate, .mfiStart, .mfiReset, .driveRun, .timerOut, .irq);
  act_timer_mfi u_mfi (.clk, .rst_n, .gateCmd, .startCmd, .clrCmd, .runCmd, .mfiGate, .mfiStart, .mfiReset,
    .driveRun);
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {16'hffff, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    if (n >= 50) n_errors++;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 16'h0);
    chk($sformatf("reg %h", a), {16'h0, e}, rd);
  endtask
  task automatic start(input logic [2:0] m);
    startCmd <= m;
    @(posedge clk);
    startCmd <= 3'h0;
  endtask
  task automatic clear(input logic [2:0] m);
    clrCmd <= m;
    repeat (5) @(posedge clk);
    clrCmd <= 3'h0;
    @(posedge clk);
  endtask
  task automatic waitOut(input int b, input logic v);
    int n;
    n = 0;
    while (timerOut[b] !== v && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("wait output", {31'h0, v}, {31'h0, timerOut[b]});
  endtask
  task automatic results;
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // clock, hang guard, sequence
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      results();
    end
  end
  initial begin
    {rst_n, psel, penable, pwrite, runCmd} = 5'h0;
    {paddr, pwdata, gateCmd, startCmd, clrCmd} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 12; i++) rdc(rA[i], rRst[i]);
    for (i = 0; i < 12; i++) begin
      apb(1'b1, rA[i], rExp[i] | (rA[i] inside {8'h1c, 8'h20, 8'h24} ? 16'hff00 : 16'h0));
      rdc(rA[i], rExp[i]);
    end
    apb(1'b0, 8'h4c, 16'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 8'h04, 16'h0200);
    rdc(8'h04, 16'h0100);
    apb(1'b1, 8'h00, 16'h0003);
    rdc(8'h04, 16'h0003);
    apb(1'b1, 8'h04, 16'h0001);
    apb(1'b1, 8'h18, 16'h0001);
    start(3'b001);
    repeat (40) @(posedge clk);
    chk("gate shut", 32'h0, {26'h0, timerOut});
    gateCmd <= 3'b001;
    waitOut(0, 1'b1);
    chk("cycle early", 32'h0, {31'h0, timerOut[1]});
    waitOut(1, 1'b1);
    start(3'b001);
    repeat (20) @(posedge clk);
    rdc(8'h40, 16'h0003);
    rdc(8'h38, 16'h0003);
    clear(3'b001);
    rdc(8'h40, 16'h0000);
    apb(1'b1, 8'h3c, 16'h0001);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'b1, 8'h38, 16'h0001);
    rdc(8'h38, 16'h0002);
    chk("irq off", 32'h0, {31'h0, irq});
    apb(1'b1, 8'h3c, 16'h0000);
    apb(1'b1, 8'h18, 16'h0000);
    apb(1'b1, 8'h10, 16'h0004);
    apb(1'b1, 8'h14, 16'h0002);
    apb(1'b1, 8'h34, 16'h1000);
    start(3'b100);
    waitOut(5, 1'b1);
    chk("cmp toggle", 32'h1, {31'h0, timerOut[4]});
    waitOut(5, 1'b0);
    chk("cmp toggle back", 32'h0, {31'h0, timerOut[4]});
    apb(1'b1, 8'h08, 16'h0002);
    apb(1'b1, 8'h0c, 16'h0001);
    for (i = 0; i < 7; i++) begin
      apb(1'b1, 8'h20, 16'(i));
      clear(3'b010);
      start(3'b010);
      if (i == 6) waitOut(2, 1'b1);
      repeat (20) @(posedge clk);
      chk("out early", {31'h0, i != 6}, {31'h0, timerOut[2]});
      repeat (2100) @(posedge clk);
      chk("out late", {31'h0, i inside {1, 2, 4, 5}}, {31'h0, timerOut[2]});
    end
    clear(3'b111);
    apb(1'b1, 8'h18, 16'h0004);
    apb(1'b1, 8'h20, 16'h0041);
    apb(1'b1, 8'h2c, 16'h1010);
    apb(1'b1, 8'h30, 16'h0033);
    runCmd <= 1'b1;
    waitOut(1, 1'b1);
    chk("cascade early", 32'h0, {31'h0, timerOut[3]});
    waitOut(3, 1'b1);
    apb(1'b1, 8'h00, 16'hffff);
    apb(1'b1, 8'h28, 16'h0001);
    rdc(8'h40, 16'h0000);
    repeat (4100) @(posedge clk);
    rdc(8'h40, 16'h0001);
    runCmd <= 1'b0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("outputs after reset", 32'h0, {26'h0, timerOut});
    rdc(8'h00, 16'h7530);
    results();
  end
endmodule
